// [src/eeps_pkg.sv]
package eeps_pkg;

	// Array geometry
	localparam int ADDR_W = 11;
	localparam int DATA_W = 8;
	localparam int PAGE_LO_W = 5;
	localparam int BLK_W = 3;
	localparam int BLK_LSB = 8;

	// Device address byte layout
	localparam int TYPE_MSB = 7;
	localparam int TYPE_LSB = 4;
	localparam int BLK_MSB_POS = 3;
	localparam int BLK_LSB_POS = 1;
	localparam int RW_POS = 0;
	localparam logic RW_READ = 1'h1;
	// Type code value is arbitrary, overridden per product
	localparam logic [3:0] DEV_TYPE_DFLT = 4'h5;

	// Bit counter: eight data bits, then the acknowledge slot
	localparam logic [3:0] LAST_BIT = 4'h8;
	localparam logic [3:0] FIRST_TX = 4'h1;

	// Pin sampling
	localparam int SYNC_DEPTH = 3;
	localparam int PIN_SCL = 0;
	localparam int PIN_SDA = 1;
	localparam int PIN_WP = 2;
	localparam int PIN_N = 3;

	// Program cycle timing
	localparam int CLK_MHZ = 250;
	localparam int EW_TIME_US = 10000;
	localparam int EW_CYCLES = EW_TIME_US * CLK_MHZ;

	typedef enum {
		ST_IDLE,
		ST_DEV,
		ST_ACK_DEV,
		ST_WADDR,
		ST_ACK_WADDR,
		ST_WDATA,
		ST_ACK_WDATA,
		ST_RDATA,
		ST_RACK
	} eeps_state_t;

	typedef struct packed {
		logic en;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} eeps_wr_t;

	typedef struct packed {
		logic start;
		logic stop;
		logic rise;
		logic fall;
	} eeps_evt_t;

	function automatic logic [ADDR_W-1:0] eeps_page_inc(input logic [ADDR_W-1:0] a);
		eeps_page_inc = {a[ADDR_W-1:PAGE_LO_W], a[PAGE_LO_W-1:0] + 5'h1};
	endfunction

	function automatic logic [ADDR_W-1:0] eeps_full_inc(input logic [ADDR_W-1:0] a);
		eeps_full_inc = a + 11'h001;
	endfunction

endpackage

// [src/eeps_mem.sv]
`timescale 1ns/1ps
module eeps_mem #(
	parameter int AW = 11,
	parameter int DW = 8
) (
	// Clock
	input wire logic clk,
	// Write port
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [DW-1:0] wdata,
	// Read port, data registered
	input wire logic [AW-1:0] raddr,
	output logic [DW-1:0] rdata_q
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	// No reset: contents survive like a real array
	always_ff @(posedge clk)
	begin
		if (we)
		begin
			mem[waddr] <= wdata;
		end
		rdata_q <= mem[raddr];
	end
endmodule // eeps_mem

// [src/eeps_slave.sv]
`timescale 1ns/1ps
module eeps_slave
	import eeps_pkg::*;
#(
	parameter logic [3:0] DEV_TYPE = eeps_pkg::DEV_TYPE_DFLT,
	parameter int EW_CYC = eeps_pkg::EW_CYCLES
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Two-wire bus pins
	input wire logic scl,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	// Control and status
	input wire logic wp,
	output logic prog_busy
);
	import eeps_pkg::*;

	localparam int EW_W = $clog2(EW_CYC + 1);

	logic [SYNC_DEPTH-1:0] pin_q [PIN_N];
	logic [PIN_N-1:0] filt_q;
	logic [PIN_N-1:0] prev_q;
	eeps_state_t state_q, state_d;
	logic [3:0] cnt_q, cnt_d;
	logic [7:0] sh_q, sh_d;
	logic [ADDR_W-1:0] addr_q, addr_d;
	logic [BLK_W-1:0] blk_q, blk_d;
	logic rw_q, rw_d;
	logic oe_q, oe_d;
	logic busy_q, busy_d;
	logic wr_seen_q, wr_seen_d;
	logic [EW_W-1:0] ew_q, ew_d;
	logic [DATA_W-1:0] rd_data;
	eeps_wr_t wr;
	eeps_evt_t evt;

	// Three-stage sampling; a level counts once stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < PIN_N; gi++)
		begin : g_sync
			always_ff @(posedge mclk or posedge rst)
			begin
				if (rst)
				begin
					pin_q[gi] <= '1;
					filt_q[gi] <= 1'h1;
					prev_q[gi] <= 1'h1;
				end
				else
				begin
					pin_q[gi] <= {pin_q[gi][SYNC_DEPTH-2:0], (gi == PIN_SCL) ? scl : (gi == PIN_SDA) ? sda_i : wp};
					if (pin_q[gi][1] == pin_q[gi][2])
					begin
						filt_q[gi] <= pin_q[gi][2];
					end
					prev_q[gi] <= filt_q[gi];
				end
			end
		end
	endgenerate

	// Bus condition decode
	wire scl_f = filt_q[PIN_SCL];
	wire sda_f = filt_q[PIN_SDA];
	wire wp_s = filt_q[PIN_WP];
	wire scl_p = prev_q[PIN_SCL];
	wire sda_p = prev_q[PIN_SDA];
	assign evt.start = scl_f & scl_p & sda_p & ~sda_f;
	assign evt.stop = scl_f & scl_p & ~sda_p & sda_f;
	assign evt.rise = scl_f & ~scl_p;
	assign evt.fall = ~scl_f & scl_p;

	wire quiet = ~busy_q & ~evt.start & ~evt.stop;
	wire byte_done = evt.fall & (cnt_q == LAST_BIT);
	wire in_rx = (state_q == ST_DEV) | (state_q == ST_WADDR) | (state_q == ST_WDATA);
	wire in_ack = (state_q == ST_ACK_DEV) | (state_q == ST_ACK_WADDR) | (state_q == ST_ACK_WDATA);
	wire type_ok = (sh_q[TYPE_MSB:TYPE_LSB] == DEV_TYPE);
	wire dev_read = (sh_q[RW_POS] == RW_READ);
	wire load_rd = quiet & evt.fall & (((state_q == ST_ACK_DEV) & rw_q) | (state_q == ST_RACK));
	wire [ADDR_W-1:0] rd_addr = addr_q;

	eeps_mem #(
		.AW(ADDR_W),
		.DW(DATA_W)
	) u_mem (
		.clk(mclk),
		.we(wr.en),
		.waddr(wr.addr),
		.wdata(wr.data),
		.raddr(rd_addr),
		.rdata_q(rd_data)
	);

	always_comb
	begin
		state_d = state_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		addr_d = addr_q;
		blk_d = blk_q;
		rw_d = rw_q;
		oe_d = oe_q;
		busy_d = busy_q;
		wr_seen_d = wr_seen_q;
		ew_d = ew_q;
		wr = '0;
		if (busy_q)
		begin
			// Pins are not looked at until the cycle ends
			state_d = ST_IDLE;
			oe_d = 1'h0;
			if (ew_q == '0)
			begin
				busy_d = 1'h0;
			end
			else
			begin
				ew_d = ew_q - EW_W'(1);
			end
		end
		else if (evt.start)
		begin
			// Repeated START keeps the address for random reads
			state_d = ST_DEV;
			cnt_d = '0;
			oe_d = 1'h0;
		end
		else if (evt.stop)
		begin
			state_d = ST_IDLE;
			oe_d = 1'h0;
			wr_seen_d = 1'h0;
			if (wr_seen_q)
			begin
				// Only a transfer that stored data starts the timed cycle
				busy_d = 1'h1;
				ew_d = EW_W'(EW_CYC - 1);
			end
		end
		else if (in_rx & evt.rise & (cnt_q != LAST_BIT))
		begin
			sh_d = {sh_q[6:0], sda_f};
			cnt_d = cnt_q + 4'h1;
		end
		else if (in_rx & byte_done)
		begin
			unique case (state_q)
				ST_DEV:
				begin
					if (type_ok)
					begin
						blk_d = sh_q[BLK_MSB_POS:BLK_LSB_POS];
						rw_d = dev_read;
						oe_d = 1'h1;
						state_d = ST_ACK_DEV;
						if (dev_read)
						begin
							// Block bits replace the top of the counter
							addr_d = {sh_q[BLK_MSB_POS:BLK_LSB_POS], addr_q[BLK_LSB-1:0]};
						end
					end
					else
					begin
						state_d = ST_IDLE;
					end
				end
				ST_WADDR:
				begin
					addr_d = {blk_q, sh_q};
					oe_d = 1'h1;
					state_d = ST_ACK_WADDR;
				end
				default:
				begin
					// Data byte; refused and dropped while protected
					oe_d = ~wp_s;
					state_d = ST_ACK_WDATA;
					if (~wp_s)
					begin
						wr.en = 1'h1;
						wr.addr = addr_q;
						wr.data = sh_q;
						addr_d = eeps_page_inc(addr_q);
						wr_seen_d = 1'h1;
					end
				end
			endcase
		end
		else if (in_ack & evt.fall)
		begin
			// Acknowledge released only at the end of the ninth clock
			oe_d = 1'h0;
			cnt_d = '0;
			if (state_q == ST_ACK_DEV)
			begin
				state_d = rw_q ? ST_RDATA : ST_WADDR;
			end
			else
			begin
				state_d = ST_WDATA;
			end
			if (load_rd)
			begin
				sh_d = rd_data;
				oe_d = ~rd_data[7];
				cnt_d = FIRST_TX;
				addr_d = eeps_full_inc(addr_q);
			end
		end
		else if ((state_q == ST_RDATA) & evt.fall)
		begin
			if (cnt_q == LAST_BIT)
			begin
				oe_d = 1'h0;
				state_d = ST_RACK;
			end
			else
			begin
				sh_d = {sh_q[6:0], 1'h0};
				oe_d = ~sh_q[6];
				cnt_d = cnt_q + 4'h1;
			end
		end
		else if ((state_q == ST_RACK) & evt.rise & sda_f)
		begin
			// Master declined: line stays released for its STOP
			state_d = ST_IDLE;
		end
		else if (load_rd)
		begin
			// Master acknowledged: next byte follows
			sh_d = rd_data;
			oe_d = ~rd_data[7];
			cnt_d = FIRST_TX;
			addr_d = eeps_full_inc(addr_q);
			state_d = ST_RDATA;
		end
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			state_q <= ST_IDLE;
			cnt_q <= '0;
			sh_q <= '0;
			addr_q <= '0;
			blk_q <= '0;
			rw_q <= 1'h0;
			oe_q <= 1'h0;
			busy_q <= 1'h0;
			wr_seen_q <= 1'h0;
			ew_q <= '0;
		end
		else
		begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			addr_q <= addr_d;
			blk_q <= blk_d;
			rw_q <= rw_d;
			oe_q <= oe_d;
			busy_q <= busy_d;
			wr_seen_q <= wr_seen_d;
			ew_q <= ew_d;
		end
	end

	// Open drain: only ever pulls low
	assign sda_o = 1'h0;
	assign sda_oe = oe_q;
	assign prog_busy = busy_q;

	property p_busy_silent;
		@(posedge mclk) disable iff (rst)
		busy_q |=> !sda_oe;
	endproperty
	a_busy_silent: assert property (p_busy_silent) else $error("drive during program cycle");

	property p_busy_ignores;
		@(posedge mclk) disable iff (rst)
		busy_q |=> state_q == ST_IDLE;
	endproperty
	a_busy_ignores: assert property (p_busy_ignores) else $error("bus activity during program cycle");

	property p_stop_prog;
		@(posedge mclk) disable iff (rst)
		(!busy_q && evt.stop && wr_seen_q) |=> busy_q && ew_q == EW_W'(EW_CYC - 1) ##1 busy_q [*8];
	endproperty
	a_stop_prog: assert property (p_stop_prog) else $error("program cycle not started");

	property p_ew_bound;
		@(posedge mclk) disable iff (rst)
		(busy_q && ew_q == '0) |=> !busy_q;
	endproperty
	a_ew_bound: assert property (p_ew_bound) else $error("program cycle not ended");

	property p_type;
		@(posedge mclk) disable iff (rst)
		(quiet && state_q == ST_DEV && byte_done && !type_ok) |=> state_q == ST_IDLE && !sda_oe;
	endproperty
	a_type: assert property (p_type) else $error("foreign address answered");

	property p_rw;
		@(posedge mclk) disable iff (rst)
		(quiet && state_q == ST_DEV && byte_done && type_ok) |=> rw_q == $past(sh_q[RW_POS]) && sda_oe;
	endproperty
	a_rw: assert property (p_rw) else $error("direction bit mishandled");

	property p_block;
		@(posedge mclk) disable iff (rst)
		(quiet && state_q == ST_WADDR && byte_done) |=> addr_q[ADDR_W-1:BLK_LSB] == blk_q && sda_oe;
	endproperty
	a_block: assert property (p_block) else $error("block bits lost");

	property p_protect;
		@(posedge mclk) disable iff (rst)
		wr.en |-> !wp_s;
	endproperty
	a_protect: assert property (p_protect) else $error("write while protected");

	property p_protect_nack;
		@(posedge mclk) disable iff (rst)
		(quiet && state_q == ST_WDATA && byte_done && wp_s) |=> !sda_oe && state_q == ST_ACK_WDATA;
	endproperty
	a_protect_nack: assert property (p_protect_nack) else $error("protected data acknowledged");

	property p_page;
		@(posedge mclk) disable iff (rst)
		wr.en |=> addr_q[ADDR_W-1:PAGE_LO_W] == $past(addr_q[ADDR_W-1:PAGE_LO_W])
			&& addr_q[PAGE_LO_W-1:0] == $past(addr_q[PAGE_LO_W-1:0]) + 5'h1 && sda_oe;
	endproperty
	a_page: assert property (p_page) else $error("page address step wrong");

	property p_read_inc;
		@(posedge mclk) disable iff (rst)
		load_rd |=> addr_q == $past(addr_q) + 11'h001 && state_q == ST_RDATA && cnt_q == FIRST_TX;
	endproperty
	a_read_inc: assert property (p_read_inc) else $error("read address step wrong");

	property p_ack_hold;
		@(posedge mclk) disable iff (rst)
		(in_ack && sda_oe && !evt.fall && quiet) |=> sda_oe;
	endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("acknowledge dropped early");

	c_page_write: cover property (@(posedge mclk) disable iff (rst) wr.en && addr_q[PAGE_LO_W-1:0] == 5'h1F);
	c_seq_read: cover property (@(posedge mclk) disable iff (rst) load_rd && state_q == ST_RACK);
	c_prog: cover property (@(posedge mclk) disable iff (rst) $fell(busy_q));
	c_protect: cover property (@(posedge mclk) disable iff (rst) state_q == ST_ACK_WDATA && wp_s);
endmodule // eeps_slave

// [testbench/eeps_mst.sv]
`timescale 1ns/1ps
module eeps_mst (
	// Clocks
	input wire logic mclk,
	input wire logic lclk,
	// Bus
	input wire logic sda_line,
	output logic scl,
	output logic sda_pull
);
	// Idle bus: clock parked high, data left to the pull-up
	initial
	begin
		scl = 1'h1;
		sda_pull = 1'h0;
	end

	// Link clock step, landing off the sampling edge
	task automatic tk();
		@(posedge lclk);
		@(negedge mclk);
	endtask

	// Data moves only while the clock is low
	task automatic bit_io(input logic b, output logic r);
		sda_pull = ~b;
		tk();
		scl = 1'h1;
		tk();
		r = sda_line;
		scl = 1'h0;
		tk();
	endtask

	task automatic start();
		sda_pull = 1'h0;
		tk();
		scl = 1'h1;
		tk();
		sda_pull = 1'h1;
		tk();
		scl = 1'h0;
		tk();
	endtask

	task automatic stop();
		sda_pull = 1'h1;
		tk();
		scl = 1'h1;
		tk();
		sda_pull = 1'h0;
		tk();
	endtask

	// Reads send all ones so the device owns the line
	task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			bit_io(tx[i], r);
			rx[i] = r;
		end
		bit_io(ack_in, ack);
	endtask
endmodule // eeps_mst

// [testbench/eeps_slave_bench.sv]
`timescale 1ns/1ps
module eeps_slave_bench;
	import eeps_pkg::*;
	// Arbitrary type code
	localparam logic [3:0] DEV_ID = 4'h9;
	// Short cycle, still longer than one addressing byte
	localparam int EW_N = 3000;
	localparam logic ACK = 1'h0;
	localparam logic NAK = 1'h1;
	logic mclk = 1'h0;
	logic lclk = 1'h0;
	logic rst = 1'h1;
	logic wp = 1'h0;
	logic scl, sda_pull, sda_o, sda_oe, prog_busy, ak;
	wire logic sda_line;
	logic [7:0] rx;
	logic [7:0] got [0:1];
	logic [15:0] run = 16'h0;
	logic [15:0] busy_len = 16'h0;
	int error_cnt = 0;
	int tests_run = 0;
	int cyc = 0;

	// Wired-AND line with pull-up
	assign sda_line = ~(sda_pull | (sda_oe & ~sda_o));

	eeps_slave #(.DEV_TYPE(DEV_ID), .EW_CYC(EW_N)) u_dut (
		.mclk(mclk),
		.rst(rst),
		.scl(scl),
		.sda_i(sda_line),
		.sda_o(sda_o),
		.sda_oe(sda_oe),
		.wp(wp),
		.prog_busy(prog_busy)
	);

	eeps_mst u_mst (
		.mclk(mclk),
		.lclk(lclk),
		.sda_line(sda_line),
		.scl(scl),
		.sda_pull(sda_pull)
	);

	initial
		forever #2 mclk = ~mclk;

	initial
	begin
		#37;
		forever #80 lclk = ~lclk;
	end

	task automatic final_report();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Busy run length, plus hang guard
	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (prog_busy === 1'h1)
			run <= run + 16'h1;
		else if (run != 16'h0)
		begin
			busy_len <= run;
			run <= 16'h0;
		end
		if (cyc == 90000)
		begin
			error_cnt++;
			final_report();
		end
	end

	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic done(input string t);
		$display("test %s finished", t);
	endtask

	task automatic dev(input logic [2:0] blk, input logic rd, input logic exp);
		u_mst.start();
		u_mst.xfer({DEV_ID, blk, rd}, 1'h1, rx, ak);
		chk("device ack", ak, exp);
	endtask

	task automatic wr(input logic [10:0] a, input int n, input logic [7:0] d0, input logic da);
		dev(a[10:8], 1'h0, ACK);
		u_mst.xfer(a[7:0], 1'h1, rx, ak);
		chk("word ack", ak, ACK);
		for (int i = 0; i < n; i++)
		begin
			u_mst.xfer(d0 + 8'(i), 1'h1, rx, ak);
			chk("data ack", ak, da);
		end
		u_mst.stop();
		repeat (8) @(negedge mclk);
		chk("busy", prog_busy, {15'h0, ~da});
		if (da == ACK)
		begin
			dev(a[10:8], 1'h0, NAK);
			u_mst.stop();
			for (int k = 0; k < 8000 && prog_busy !== 1'h0; k++)
				@(negedge mclk);
			@(negedge mclk);
			chk("busy length", busy_len, 16'(EW_N));
		end
	endtask

	task automatic rd(input logic [10:0] a, input logic rnd, input int n);
		if (rnd)
		begin
			dev(a[10:8], 1'h0, ACK);
			u_mst.xfer(a[7:0], 1'h1, rx, ak);
			chk("dummy word ack", ak, ACK);
		end
		dev(a[10:8], 1'h1, ACK);
		for (int i = 0; i < n; i++)
			u_mst.xfer(8'hFF, i == n - 1, got[i], ak);
		u_mst.stop();
	endtask

	initial
	begin
		repeat (12) @(negedge mclk);
		rst = 1'h0;
		repeat (8) @(negedge mclk);
		u_mst.start();
		u_mst.xfer({~DEV_ID, 4'h0}, 1'h1, rx, ak);
		chk("foreign type", ak, NAK);
		u_mst.stop();
		done("type code");
		wr(11'h51E, 3, 8'hA0, ACK);
		done("page write");
		wp = 1'h1;
		wr(11'h51E, 1, 8'h55, NAK);
		wp = 1'h0;
		done("protected write");
		rd(11'h500, 1'h1, 1);
		chk("page wrap", got[0], 8'hA2);
		rd(11'h51E, 1'h1, 1);
		chk("random read", got[0], 8'hA0);
		rd(11'h500, 1'h0, 1);
		chk("current read", got[0], 8'hA1);
		done("reads");
		wr(11'h7FF, 1, 8'hC3, ACK);
		wr(11'h000, 1, 8'hC4, ACK);
		rd(11'h7FF, 1'h1, 2);
		chk("wrap byte 0", got[0], 8'hC3);
		chk("wrap byte 1", got[1], 8'hC4);
		done("array wrap");
		final_report();
	end
endmodule // eeps_slave_bench
